// ===== nvmc_map.svh
// Register offsets, field positions, reset values and timing counts of the NVM command controller
`ifndef NVMC_MAP_SVH
`define NVMC_MAP_SVH

`define NVMC_OFF_CMD 4'h0
`define NVMC_OFF_LOCK 4'h1
`define NVMC_OFF_STATUS 4'h2
`define NVMC_OFF_INTEN 4'h3
`define NVMC_OFF_INTFLAG 4'h4
`define NVMC_OFF_DATA_LO 4'h6
`define NVMC_OFF_DATA_HI 4'h7
`define NVMC_OFF_ADDR_LO 4'h8
`define NVMC_OFF_ADDR_HI 4'h9
`define NVMC_OFF_KEY 4'ha

`define NVMC_LOCK_APP_BIT 0
`define NVMC_LOCK_BOOT_BIT 1
`define NVMC_ST_FLASH_BIT 0
`define NVMC_ST_EE_BIT 1
`define NVMC_ST_FAULT_BIT 2
`define NVMC_READY_BIT 0

`define NVMC_RESET_BYTE 8'h00
`define NVMC_RESET_WORD 16'h0000
`define NVMC_KEY_VALUE 8'h9d
`define NVMC_IRQ_VECTOR 8'h00
`define NVMC_KEY_WINDOW 3'h4

`endif

// ===== nvmc_pkg.sv
// Types of the NVM command controller
package nvmc_pkg;

    typedef enum logic [2:0] {
        NVMC_CMD_NONE = 3'h0,
        NVMC_CMD_PAGE_WRITE = 3'h1,
        NVMC_CMD_PAGE_ERASE = 3'h2,
        NVMC_CMD_ERASE_WRITE = 3'h3,
        NVMC_CMD_BUF_CLEAR = 3'h4,
        NVMC_CMD_FULL_ERASE = 3'h5,
        NVMC_CMD_EE_WIPE = 3'h6,
        NVMC_CMD_FUSE_PROG = 3'h7
    } nvmc_cmd_t;

    typedef enum logic [3:0] {
        NVMC_ST_IDLE = 4'b0001,
        NVMC_ST_BUSY = 4'b0010,
        NVMC_ST_SLEEP = 4'b0100,
        NVMC_ST_HOLD = 4'b1000
    } nvmc_state_t;

    // Command handed to the memory arrays
    typedef struct packed {
        logic start;
        nvmc_cmd_t cmd;
        logic to_flash;
        logic to_eeprom;
        logic [15:0] addr;
        logic [15:0] data;
    } nvmc_array_req_t;

    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } nvmc_bus_req_t;

endpackage

// ===== nvmc_controller.sv
// NVM command controller: register bank, key unlock, command sequencing, locks and sleep handling
//
// Design decision made here: the plain strobed port.
`include "nvmc_map.svh"

module nvmc_controller #(
    parameter int ADDR_W = 16,
    parameter logic [15:0] EEPROM_BASE = 16'h1400,
    parameter logic [15:0] EEPROM_END = 16'h14ff,
    parameter logic [15:0] FLASH_BASE = 16'h8000,
    parameter logic [15:0] BOOT_END = 16'h8400,
    parameter logic [15:0] APP_END = 16'h8800
) (
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire nvmc_pkg::nvmc_bus_req_t bus_req,
    input wire logic bus_from_debug,
    output logic [7:0] bus_rdata,
    // Page buffer write notification (address of the store)
    input wire logic buf_store,
    input wire logic [15:0] buf_store_addr,
    // CPU context
    input wire logic instr_done,
    input wire logic [15:0] fetch_addr,
    input wire logic boot_read,
    // Fuse and system sleep
    input wire logic eeprom_preserve_fuse,
    input wire logic sys_sleep,
    input wire logic sleep_idle_mode,
    // Array side
    output nvmc_pkg::nvmc_array_req_t array_req,
    input wire logic array_done,
    output logic buf_clear,
    output logic boot_zero,
    output logic irq,
    output logic [7:0] irq_vector,
    output logic wake_req,
    output logic keep_clock,
    output logic ctrl_asleep
);
    import nvmc_pkg::*;

    initial begin
        if (ADDR_W != 16) begin
            $error("nvmc_controller serves a 16-bit address only");
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    nvmc_state_t state;
    nvmc_state_t next_state;
    logic [2:0] cmd_field;
    logic app_code_protect;
    logic boot_lock_pending;
    logic boot_section_lock;
    logic write_fault;
    logic flash_busy;
    logic eeprom_busy;
    logic ready_enable;
    logic eeprom_ready;
    logic [15:0] fuse_value;
    logic [15:0] target_location;
    logic [2:0] key_count;
    logic buf_in_flash;
    logic buf_in_eeprom;

    // ************************************************************
    // Decode
    // ************************************************************
    wire wr = bus_req.wr;
    wire [3:0] a = bus_req.addr;
    wire [7:0] wd = bus_req.wdata;
    wire in_boot = fetch_addr >= FLASH_BASE && fetch_addr < BOOT_END;
    wire key_wr = wr && a == `NVMC_OFF_KEY && wd == `NVMC_KEY_VALUE;
    wire unlocked = key_count != 3'h0;
    wire cmd_wr = wr && a == `NVMC_OFF_CMD && unlocked;
    wire lock_wr = wr && a == `NVMC_OFF_LOCK;
    wire ready_clr = wr && a == `NVMC_OFF_INTFLAG && wd[`NVMC_READY_BIT];
    wire nvmc_cmd_t new_cmd = nvmc_cmd_t'(wd[2:0]);
    wire addr_is_ee = target_location >= EEPROM_BASE && target_location <= EEPROM_END;
    wire addr_is_flash = target_location >= FLASH_BASE;
    wire addr_in_app = target_location >= BOOT_END && target_location < APP_END;
    wire addr_in_boot = addr_is_flash && target_location < BOOT_END;
    wire is_page = new_cmd == NVMC_CMD_PAGE_WRITE || new_cmd == NVMC_CMD_PAGE_ERASE
        || new_cmd == NVMC_CMD_ERASE_WRITE;
    // Protected area: boot never CPU-writable, app code when protected
    wire prot_hit = is_page && addr_is_flash && (addr_in_boot || (app_code_protect && addr_in_app));
    wire mixed_buf = is_page && buf_in_flash && buf_in_eeprom;
    wire fuse_denied = new_cmd == NVMC_CMD_FUSE_PROG && !bus_from_debug;
    wire cmd_bad = prot_hit || mixed_buf || fuse_denied;
    wire busy_now = flash_busy || eeprom_busy;
    wire cmd_go = cmd_wr && !busy_now && new_cmd != NVMC_CMD_NONE && new_cmd != NVMC_CMD_BUF_CLEAR && !cmd_bad;
    wire go_ee = is_page ? addr_is_ee : new_cmd == NVMC_CMD_EE_WIPE
        || (new_cmd == NVMC_CMD_FULL_ERASE && !eeprom_preserve_fuse);
    wire go_flash = is_page ? addr_is_flash : new_cmd == NVMC_CMD_FULL_ERASE
        || new_cmd == NVMC_CMD_FUSE_PROG;
    // Any exit from sleep, asleep or held by a write, clears the buffer
    wire waking = (state == NVMC_ST_SLEEP || state == NVMC_ST_HOLD) && !sys_sleep;

    // ************************************************************
    // Sleep and operation state
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            NVMC_ST_IDLE: begin
                if (cmd_go) begin
                    next_state = NVMC_ST_BUSY;
                end else if (sys_sleep) begin
                    next_state = NVMC_ST_SLEEP;
                end
            end
            NVMC_ST_BUSY: begin
                if (array_done) begin
                    next_state = NVMC_ST_IDLE;
                end else if (sys_sleep) begin
                    next_state = NVMC_ST_HOLD;
                end
            end
            NVMC_ST_HOLD: begin
                if (array_done) begin
                    next_state = sys_sleep ? NVMC_ST_SLEEP : NVMC_ST_IDLE;
                end else if (!sys_sleep) begin
                    next_state = NVMC_ST_BUSY;
                end
            end
            NVMC_ST_SLEEP: begin
                if (!sys_sleep) begin
                    next_state = NVMC_ST_IDLE;
                end
            end
            default: begin
                next_state = NVMC_ST_IDLE;
            end
        endcase
    end

    // Reset returns to idle, dropping any operation underway
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= NVMC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Key window and command register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            key_count <= 3'h0;
        end else if (key_wr) begin
            key_count <= `NVMC_KEY_WINDOW;
        end else if (cmd_wr) begin
            key_count <= 3'h0;
        end else if (instr_done && unlocked) begin
            key_count <= key_count - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_field <= 3'h0;
        end else if (cmd_wr) begin
            cmd_field <= wd[2:0];
        end else if (array_done) begin
            cmd_field <= 3'h0;
        end
    end

    // ************************************************************
    // Busy, fault and array request
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_busy <= 1'b0;
            eeprom_busy <= 1'b0;
            write_fault <= 1'b0;
            array_req <= '0;
        end else begin
            array_req.start <= cmd_go;
            if (cmd_go) begin
                flash_busy <= go_flash;
                eeprom_busy <= go_ee;
                array_req.cmd <= new_cmd;
                array_req.to_flash <= go_flash;
                array_req.to_eeprom <= go_ee;
                array_req.addr <= target_location;
                array_req.data <= fuse_value;
            end else if (array_done) begin
                flash_busy <= 1'b0;
                eeprom_busy <= 1'b0;
            end
            if (cmd_wr && new_cmd != NVMC_CMD_NONE) begin
                write_fault <= cmd_bad;
            end
        end
    end

    // ************************************************************
    // Page buffer tracking and clear
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst || buf_clear) begin
            buf_in_flash <= 1'b0;
            buf_in_eeprom <= 1'b0;
        end else if (buf_store) begin
            buf_in_flash <= buf_in_flash || buf_store_addr >= FLASH_BASE;
            buf_in_eeprom <= buf_in_eeprom || buf_store_addr < FLASH_BASE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            buf_clear <= 1'b1;
        end else begin
            buf_clear <= waking || array_done || (cmd_wr && new_cmd == NVMC_CMD_BUF_CLEAR);
        end
    end

    // ************************************************************
    // Section locks
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            app_code_protect <= 1'b0;
            boot_lock_pending <= 1'b0;
            boot_section_lock <= 1'b0;
        end else begin
            if (lock_wr && wd[`NVMC_LOCK_APP_BIT]) begin
                app_code_protect <= 1'b1;
            end
            if (lock_wr && wd[`NVMC_LOCK_BOOT_BIT] && in_boot) begin
                boot_lock_pending <= 1'b1;
            end
            if (boot_lock_pending && !in_boot) begin
                boot_section_lock <= 1'b1;
            end
        end
    end

    // Zero boot reads and fetches once locked
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_zero <= 1'b0;
        end else begin
            boot_zero <= boot_section_lock && (boot_read || in_boot);
        end
    end

    // ************************************************************
    // Interrupt source
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ready_enable <= 1'b0;
            eeprom_ready <= 1'b0;
        end else begin
            if (wr && a == `NVMC_OFF_INTEN) begin
                ready_enable <= wd[`NVMC_READY_BIT];
            end
            if (!eeprom_busy) begin
                eeprom_ready <= 1'b1;
            end else if (ready_clr) begin
                eeprom_ready <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
            irq_vector <= `NVMC_IRQ_VECTOR;
            wake_req <= 1'b0;
            keep_clock <= 1'b0;
            ctrl_asleep <= 1'b0;
        end else begin
            irq <= ready_enable && eeprom_ready;
            irq_vector <= `NVMC_IRQ_VECTOR;
            wake_req <= ready_enable && eeprom_ready && sys_sleep && sleep_idle_mode;
            keep_clock <= next_state == NVMC_ST_BUSY || next_state == NVMC_ST_HOLD;
            ctrl_asleep <= next_state == NVMC_ST_SLEEP;
        end
    end

    // ************************************************************
    // Address, data and read-back
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            fuse_value <= `NVMC_RESET_WORD;
            target_location <= `NVMC_RESET_WORD;
        end else begin
            if (wr && a == `NVMC_OFF_DATA_LO) fuse_value[7:0] <= wd;
            if (wr && a == `NVMC_OFF_DATA_HI) fuse_value[15:8] <= wd;
            if (buf_store) begin
                target_location <= buf_store_addr;
            end else begin
                if (wr && a == `NVMC_OFF_ADDR_LO) target_location[7:0] <= wd;
                if (wr && a == `NVMC_OFF_ADDR_HI) target_location[15:8] <= wd;
            end
        end
    end

    logic [7:0] rd_mux;
    always_comb begin
        case (a)
            `NVMC_OFF_CMD: rd_mux = {5'h00, cmd_field};
            `NVMC_OFF_LOCK: rd_mux = {6'h00, boot_lock_pending, app_code_protect};
            `NVMC_OFF_STATUS: rd_mux = {5'h00, write_fault, eeprom_busy, flash_busy};
            `NVMC_OFF_INTEN: rd_mux = {7'h00, ready_enable};
            `NVMC_OFF_INTFLAG: rd_mux = {7'h00, eeprom_ready};
            `NVMC_OFF_DATA_LO: rd_mux = fuse_value[7:0];
            `NVMC_OFF_DATA_HI: rd_mux = fuse_value[15:8];
            `NVMC_OFF_ADDR_LO: rd_mux = target_location[7:0];
            `NVMC_OFF_ADDR_HI: rd_mux = target_location[15:8];
            default: rd_mux = `NVMC_RESET_BYTE;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= `NVMC_RESET_BYTE;
        end else begin
            bus_rdata <= bus_req.rd ? rd_mux : `NVMC_RESET_BYTE;
        end
    end

endmodule // nvmc_controller

// ===== nvmc_controller_properties.sv
// Port-level checks of the NVM command controller
module nvmc_controller_properties #(
    parameter logic [15:0] EEPROM_BASE = 16'h1400,
    parameter logic [15:0] EEPROM_END = 16'h14ff
) (
    input wire logic clk,
    input wire logic rst,
    input wire nvmc_pkg::nvmc_bus_req_t bus_req,
    input wire logic bus_from_debug,
    input wire logic [7:0] bus_rdata,
    input wire logic eeprom_preserve_fuse,
    input wire logic sys_sleep,
    input wire logic sleep_idle_mode,
    input wire nvmc_pkg::nvmc_array_req_t array_req,
    input wire logic array_done,
    input wire logic buf_clear,
    input wire logic [7:0] irq_vector,
    input wire logic wake_req,
    input wire logic keep_clock,
    input wire logic ctrl_asleep
);
    import nvmc_pkg::*;
    // ****
    // Command steps
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cmd_taken;
        bus_req.wr && bus_req.addr == 4'h0;
    endsequence
    sequence s_started;
        array_req.start;
    endsequence
    // Array request and vector checks
    a_vector_fixed: assert property (irq_vector == 8'h00) else $error("vector not zero");
    a_start_single: assert property (s_started |=> !array_req.start) else $error("start too long");
    a_page_target: assert property (array_req.start && array_req.cmd inside {NVMC_CMD_PAGE_WRITE,
        NVMC_CMD_PAGE_ERASE, NVMC_CMD_ERASE_WRITE} |-> array_req.to_flash != array_req.to_eeprom &&
        array_req.to_eeprom == (array_req.addr >= EEPROM_BASE && array_req.addr <= EEPROM_END))
        else $error("page target wrong");
    a_fuse_debug: assert property (s_cmd_taken ##1 (array_req.start && array_req.cmd == NVMC_CMD_FUSE_PROG)
        |-> $past(bus_from_debug)) else $error("fuse write from cpu");
    a_erase_preserve: assert property (array_req.start && array_req.cmd == NVMC_CMD_FULL_ERASE
        |-> array_req.to_flash && array_req.to_eeprom == !eeprom_preserve_fuse) else $error("erase target");
    a_start_busy: assert property (array_req.start && array_req.cmd != NVMC_CMD_BUF_CLEAR |=> keep_clock)
        else $error("no busy");
    // Sleep and read-back checks
    a_busy_held: assert property (keep_clock && !array_done |=> keep_clock) else $error("busy dropped");
    a_awake_busy: assert property (keep_clock |-> !ctrl_asleep) else $error("asleep while busy");
    a_sleep_entry: assert property ((sys_sleep && !keep_clock)[*3] |-> ctrl_asleep) else $error("no sleep");
    a_wake_clear: assert property ($fell(sys_sleep) |-> ##[1:2] buf_clear) else $error("buffer kept");
    a_wake_idle: assert property (wake_req |-> $past(sys_sleep && sleep_idle_mode)) else $error("bad wake");
    a_read_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00) else $error("stray data");
endmodule // nvmc_controller_properties

bind nvmc_controller nvmc_controller_properties #(.EEPROM_BASE(EEPROM_BASE), .EEPROM_END(EEPROM_END)) u_props (.*);

// ===== nvmc_array_model.sv
// Behavioural model of the Flash and EEPROM arrays
module nvmc_array_model (
    input wire logic clk,
    input wire logic rst,
    input wire nvmc_pkg::nvmc_array_req_t array_req,
    input wire logic [7:0] latency,
    output logic array_done
);
    import nvmc_pkg::*;
    logic active;
    logic [7:0] count;
    // ****
    // Operation timer
    // ****
    // Done pulses latency plus two cycles after start; reset drops the operation
    always_ff @(posedge clk) begin
        if (rst) begin
            active <= 1'b0;
            count <= 8'h00;
            array_done <= 1'b0;
        end else begin
            array_done <= active && count == 8'h00;
            if (array_req.start) begin
                active <= 1'b1;
                count <= latency;
            end else if (active) begin
                active <= count != 8'h00;
                count <= count - 8'h01;
            end
        end
    end
endmodule // nvmc_array_model

// ===== test_nvm_command_controller.sv
// Self-checking bench of the NVM command controller
module test_nvm_command_controller import nvmc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    nvmc_bus_req_t bus_req = '0;
    logic dbg = 1'b0, buf_store = 1'b0, instr_done = 1'b0, boot_read = 1'b0;
    logic fuse = 1'b0, sys_sleep = 1'b0, idle_mode = 1'b0;
    logic [15:0] store_addr = 16'h1412, fetch_addr = 16'h8000;
    logic [7:0] latency = 8'h03, bus_rdata, irq_vector;
    nvmc_array_req_t array_req;
    logic array_done, buf_clear, boot_zero, irq, wake_req, keep_clock, ctrl_asleep;
    int failures = 0;
    int tests_run = 0;
    // Design and array model
    nvmc_controller DUT (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_from_debug(dbg), .bus_rdata(bus_rdata),
        .buf_store(buf_store), .buf_store_addr(store_addr), .instr_done(instr_done), .fetch_addr(fetch_addr),
        .boot_read(boot_read), .eeprom_preserve_fuse(fuse), .sys_sleep(sys_sleep), .sleep_idle_mode(idle_mode),
        .array_req(array_req), .array_done(array_done), .buf_clear(buf_clear), .boot_zero(boot_zero), .irq(irq),
        .irq_vector(irq_vector), .wake_req(wake_req), .keep_clock(keep_clock), .ctrl_asleep(ctrl_asleep));
    nvmc_array_model u_array (.clk(clk), .rst(rst), .array_req(array_req), .latency(latency),
        .array_done(array_done));
    // ****
    // Bus and check tasks
    // ****
    always #5 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus_req <= '0;
        #1;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        bus_req <= '0;
        #1;
        check(bus_rdata, exp);
    endtask
    task automatic cmd(input logic [2:0] c);
        wr(4'ha, 8'h9d);
        wr(4'h0, {5'h00, c});
    endtask
    task automatic settle;
        for (int n = 0; n < 300 && keep_clock !== 1'b0; n++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic edge_set;
        @(posedge clk);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        check(irq_vector, 8'h00);
        for (int a = 0; a < 16; a++) if (a != 10) rchk(a[3:0], a == 4 ? 8'h01 : 8'h00);
    endtask
    task automatic t_ee_write;
        edge_set;
        latency <= 8'd20;
        buf_store <= 1'b1;
        edge_set;
        buf_store <= 1'b0;
        rchk(4'h8, 8'h12);
        rchk(4'h9, 8'h14);
        cmd(3'h1);
        check({array_req.start, array_req.cmd, array_req.to_flash, array_req.to_eeprom}, 6'h25);
        wr(4'h3, 8'h01);
        check(array_req.addr, 16'h1412);
        rchk(4'h2, 8'h02);
        wr(4'h4, 8'h01);
        rchk(4'h4, 8'h00);
        check(irq, 1'b0);
        settle;
        check(irq, 1'b1);
        rchk(4'h2, 8'h00);
        wr(4'h3, 8'h00);
    endtask
    task automatic t_key;
        wr(4'h0, 8'h01);
        check(array_req.start, 1'b0);
        rchk(4'h0, 8'h00);
        for (int n = 3; n < 5; n++) begin
            wr(4'ha, 8'h9d);
            repeat (n) begin
                edge_set;
                instr_done <= 1'b1;
                edge_set;
                instr_done <= 1'b0;
            end
            wr(4'h0, 8'h01);
            check(array_req.start, n == 3);
            settle;
        end
    endtask
    task automatic t_flash;
        wr(4'h8, 8'h00);
        wr(4'h9, 8'h88);
        cmd(3'h2);
        check({array_req.to_flash, array_req.to_eeprom}, 2'b10);
        rchk(4'h2, 8'h01);
        settle;
        cmd(3'h7);
        check(array_req.start, 1'b0);
        rchk(4'h2, 8'h04);
        edge_set;
        dbg <= 1'b1;
        cmd(3'h7);
        check(array_req.start, 1'b1);
        settle;
        dbg <= 1'b0;
    endtask
    task automatic t_commands;
        for (int c = 1; c < 7; c++) begin
            cmd(c[2:0]);
            check(array_req.start | buf_clear, 1'b1);
            if (array_req.start === 1'b1) check(array_req.cmd, c[2:0]);
            settle;
        end
        for (int f = 0; f < 2; f++) begin
            edge_set;
            fuse <= f[0];
            cmd(3'h5);
            check({array_req.to_flash, array_req.to_eeprom}, {1'b1, !f[0]});
            settle;
        end
    endtask
    task automatic t_protect;
        wr(4'h1, 8'h01);
        wr(4'h1, 8'h00);
        rchk(4'h1, 8'h01);
        wr(4'h9, 8'h84);
        cmd(3'h1);
        check(array_req.start, 1'b0);
        rchk(4'h2, 8'h04);
    endtask
    task automatic t_sleep;
        logic b;
        wr(4'h9, 8'h14);
        edge_set;
        latency <= 8'd40;
        idle_mode <= 1'b1;
        cmd(3'h1);
        wr(4'h3, 8'h01);
        edge_set;
        sys_sleep <= 1'b1;
        repeat (10) edge_set;
        #1;
        check({keep_clock, ctrl_asleep}, 2'b10);
        settle;
        check({ctrl_asleep, wake_req}, 2'b11);
        idle_mode <= 1'b0;
        repeat (3) edge_set;
        #1;
        check(wake_req, 1'b0);
        sys_sleep <= 1'b0;
        edge_set;
        #1;
        b = buf_clear;
        edge_set;
        #1;
        check(b | buf_clear, 1'b1);
        wr(4'h3, 8'h00);
    endtask
    task automatic t_boot;
        wr(4'h1, 8'h02);
        boot_read <= 1'b1;
        repeat (3) edge_set;
        #1;
        check(boot_zero, 1'b0);
        fetch_addr <= 16'h8500;
        repeat (3) edge_set;
        #1;
        check(boot_zero, 1'b1);
        boot_read <= 1'b0;
        fetch_addr <= 16'h8000;
        repeat (3) edge_set;
        #1;
        check(boot_zero, 1'b1);
        rchk(4'h1, 8'h03);
    endtask
    task automatic t_abort;
        cmd(3'h1);
        repeat (5) edge_set;
        rst <= 1'b1;
        repeat (2) edge_set;
        rst <= 1'b0;
        repeat (45) edge_set;
        #1;
        check({keep_clock, array_done}, 2'b00);
        rchk(4'h1, 8'h00);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) edge_set;
        rst <= 1'b0;
        t_reset;
        t_ee_write;
        t_key;
        t_flash;
        t_commands;
        t_protect;
        t_sleep;
        t_boot;
        t_abort;
        complete_run;
    end
    // Watchdog against a hang
    initial begin
        #100000;
        failures++;
        complete_run;
    end
endmodule // test_nvm_command_controller
